// File: verilog/pcpb_ctrl.sv
// phy control upper byte: crossover, pause resolution, self-test, ahb-lite slave
`timescale 1ns/1ps
// Overview of operation
// - auto crossover enable bit, reset from strap
// - force crossover swaps transmit and receive pairs
// - pause receive result from ability bits
// - pause transmit result from ability bits
// - pause results only per table, full duplex
// - force error injects one error, self-clears
// - sequence select: long or short prbs
// - run bit; result latches, cleared on stop
// - self-test errors counted, readable by software
module pcpb_ctrl #(
	parameter int COUNT_W = 16
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic hsel_in,
	input wire logic [pcpb_pkg::ADDR_W-1:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic xover_strap_in,
	input wire logic an_complete_in,
	input wire logic hcd_full_duplex_in,
	input wire logic [1:0] local_ability_advert_in,
	input wire logic [1:0] partner_ability_in,
	output logic auto_crossover_enable_out,
	output logic force_crossover_out,
	output logic pause_rx_out,
	output logic pause_tx_out,
	output logic selftest_run_out,
	output logic long_sequence_select_out,
	output logic irq_out
);
	generate
		if (COUNT_W < 1 || COUNT_W > 32)
		begin : g_bad_count_w
			$error("COUNT_W must lie between 1 and 32");
		end
	endgenerate

	typedef struct packed {
		pcpb_pkg::pcpb_bus_t bus;
		logic [pcpb_pkg::ADDR_W-1:0] addr;
		logic [31:0] rdata;
		logic ready;
		logic strap_s1;
		logic strap_s2;
		logic [1:0] strap_wait;
		logic strap_done;
		logic xover_en;
		logic force_xover;
		logic pause_rx;
		logic pause_tx;
		logic force_err;
		logic long_seq;
		logic run;
		logic [pcpb_pkg::INT_W-1:0] int_status;
		logic [pcpb_pkg::INT_W-1:0] int_mask;
		logic irq;
	} pcpb_ctrl_state_t;

	pcpb_ctrl_state_t state;
	pcpb_ctrl_state_t next_state;

	pcpb_st_if #(.COUNT_W(COUNT_W)) st_link ();

	pcpb_selftest #(
		.COUNT_W(COUNT_W)
	) u_selftest (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.st(st_link.st)
	);

	// byte address of a register index
	function automatic logic [pcpb_pkg::ADDR_W-1:0] pcpb_byte_addr(
		input logic [7:0] idx
	);
		return pcpb_pkg::ADDR_W'({idx, 2'b00});
	endfunction : pcpb_byte_addr

	// pause resolution, returns {rx, tx}
	function automatic logic [1:0] pcpb_pause_resolve(
		input logic [1:0] loc,
		input logic [1:0] lp
	);
		logic rx;
		logic tx;
		rx = 1'b0;
		tx = 1'b0;
		if (loc[pcpb_pkg::ABIL_PAUSE] && lp[pcpb_pkg::ABIL_PAUSE])
		begin
			rx = 1'b1;
			tx = 1'b1;
		end
		else if (loc[pcpb_pkg::ABIL_PAUSE] && loc[pcpb_pkg::ABIL_ASYM]
			&& !lp[pcpb_pkg::ABIL_PAUSE] && lp[pcpb_pkg::ABIL_ASYM])
		begin
			rx = 1'b1;
		end
		else if (!loc[pcpb_pkg::ABIL_PAUSE] && loc[pcpb_pkg::ABIL_ASYM]
			&& lp[pcpb_pkg::ABIL_PAUSE] && lp[pcpb_pkg::ABIL_ASYM])
		begin
			tx = 1'b1;
		end
		return {rx, tx};
	endfunction : pcpb_pause_resolve

	logic [15:0] phy_control_rd;
	logic [1:0] pause_res;
	logic addr_take;
	logic [pcpb_pkg::INT_W-1:0] events;

	always_comb
	begin
		next_state = state;
		phy_control_rd = '0;
		phy_control_rd[pcpb_pkg::BIT_XOVER_EN] = state.xover_en;
		phy_control_rd[pcpb_pkg::BIT_FORCE_XOVER] = state.force_xover;
		phy_control_rd[pcpb_pkg::BIT_PAUSE_RX] = state.pause_rx;
		phy_control_rd[pcpb_pkg::BIT_PAUSE_TX] = state.pause_tx;
		phy_control_rd[pcpb_pkg::BIT_FORCE_ERR] = state.force_err;
		phy_control_rd[pcpb_pkg::BIT_LONG_SEQ] = state.long_seq;
		phy_control_rd[pcpb_pkg::BIT_RESULT] = st_link.result;
		phy_control_rd[pcpb_pkg::BIT_RUN] = state.run;

		// strap synchroniser and one-time capture after reset release
		next_state.strap_s1 = xover_strap_in;
		next_state.strap_s2 = state.strap_s1;
		if (!state.strap_done)
		begin
			if (state.strap_wait == pcpb_pkg::STRAP_SETTLE)
			begin
				next_state.xover_en = state.strap_s2;
				next_state.strap_done = 1'b1;
			end
			else
			begin
				next_state.strap_wait = state.strap_wait + 1'b1;
			end
		end

		next_state.force_err = 1'b0;

		if (an_complete_in && hcd_full_duplex_in)
		begin
			pause_res = pcpb_pause_resolve(local_ability_advert_in, partner_ability_in);
		end
		else
		begin
			pause_res = 2'b00;
		end
		next_state.pause_rx = pause_res[1];
		next_state.pause_tx = pause_res[0];

		events = '0;
		events[pcpb_pkg::INT_SELFTEST_ERR] = st_link.err_pulse;
		events[pcpb_pkg::INT_PAUSE_CHANGE] = (pause_res != {state.pause_rx, state.pause_tx});

		// data phase of the previous transfer
		next_state.ready = 1'b1;
		next_state.bus = pcpb_pkg::PCPB_BUS_IDLE;
		case (state.bus)
			pcpb_pkg::PCPB_BUS_WRITE:
			begin
				if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_PHY_CONTROL))
				begin
					next_state.xover_en = hwdata_in[pcpb_pkg::BIT_XOVER_EN];
					next_state.strap_done = 1'b1;
					next_state.force_xover = hwdata_in[pcpb_pkg::BIT_FORCE_XOVER];
					next_state.force_err = hwdata_in[pcpb_pkg::BIT_FORCE_ERR];
					next_state.long_seq = hwdata_in[pcpb_pkg::BIT_LONG_SEQ];
					next_state.run = hwdata_in[pcpb_pkg::BIT_RUN];
				end
				else if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_INT_STATUS))
				begin
					next_state.int_status = state.int_status
						& ~hwdata_in[pcpb_pkg::INT_W-1:0];
				end
				else if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_INT_MASK))
				begin
					next_state.int_mask = hwdata_in[pcpb_pkg::INT_W-1:0];
				end
			end
			pcpb_pkg::PCPB_BUS_RDWAIT:
			begin
				next_state.rdata = '0;
				if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_PHY_CONTROL))
				begin
					next_state.rdata[15:0] = phy_control_rd;
				end
				else if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_ERR_COUNT))
				begin
					next_state.rdata[COUNT_W-1:0] = st_link.err_count;
				end
				else if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_INT_STATUS))
				begin
					next_state.rdata[pcpb_pkg::INT_W-1:0] = state.int_status;
				end
				else if (state.addr == pcpb_byte_addr(pcpb_pkg::REG_IDX_INT_MASK))
				begin
					next_state.rdata[pcpb_pkg::INT_W-1:0] = state.int_mask;
				end
			end
			default:
			begin
				next_state.bus = pcpb_pkg::PCPB_BUS_IDLE;
			end
		endcase

		// address phase of a new transfer
		addr_take = hsel_in && hready_in && (htrans_in == pcpb_pkg::HTRANS_NONSEQ);
		if (addr_take)
		begin
			next_state.addr = {haddr_in[pcpb_pkg::ADDR_W-1:2], 2'b00};
			if (hwrite_in)
			begin
				next_state.bus = pcpb_pkg::PCPB_BUS_WRITE;
			end
			else
			begin
				next_state.bus = pcpb_pkg::PCPB_BUS_RDWAIT;
				next_state.ready = 1'b0;
			end
		end

		// events set after the clear so a same-cycle event survives
		next_state.int_status = next_state.int_status | events;
		next_state.irq = |(next_state.int_status & next_state.int_mask);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= '0;
			state.bus <= pcpb_pkg::PCPB_BUS_IDLE;
			state.ready <= 1'b1;
			state.force_xover <= pcpb_pkg::RESET_FORCE_XOVER;
			state.long_seq <= pcpb_pkg::RESET_LONG_SEQ;
			state.run <= pcpb_pkg::RESET_RUN;
			state.int_mask <= pcpb_pkg::INT_MASK_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign st_link.run = state.run;
	assign st_link.long_seq = state.long_seq;
	assign st_link.force_err = state.force_err;

	assign hrdata_out = state.rdata;
	assign hreadyout_out = state.ready;
	assign hresp_out = pcpb_pkg::HRESP_OKAY;
	assign auto_crossover_enable_out = state.xover_en;
	assign force_crossover_out = state.force_xover;
	assign pause_rx_out = state.pause_rx;
	assign pause_tx_out = state.pause_tx;
	assign selftest_run_out = state.run;
	assign long_sequence_select_out = state.long_seq;
	assign irq_out = state.irq;
endmodule : pcpb_ctrl

// File: verilog/pcpb_pkg.sv
// constants for the phy control upper-byte register block
package pcpb_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] REG_IDX_PHY_CONTROL = 8'h19;
	localparam logic [7:0] REG_IDX_ERR_COUNT = 8'h1b;
	localparam logic [7:0] REG_IDX_INT_STATUS = 8'h1c;
	localparam logic [7:0] REG_IDX_INT_MASK = 8'h1d;
	localparam int ADDR_W = 8;

	// phy_control field positions
	localparam int BIT_XOVER_EN = 15;
	localparam int BIT_FORCE_XOVER = 14;
	localparam int BIT_PAUSE_RX = 13;
	localparam int BIT_PAUSE_TX = 12;
	localparam int BIT_FORCE_ERR = 11;
	localparam int BIT_LONG_SEQ = 10;
	localparam int BIT_RESULT = 9;
	localparam int BIT_RUN = 8;

	// ability field layout, bits 11:10 of the advert registers
	localparam int ABIL_ASYM = 1;
	localparam int ABIL_PAUSE = 0;

	// interrupt status bits
	localparam int INT_W = 2;
	localparam int INT_SELFTEST_ERR = 0;
	localparam int INT_PAUSE_CHANGE = 1;
	localparam logic [INT_W-1:0] INT_MASK_RESET = 2'h0;

	// reset values
	localparam logic RESET_FORCE_XOVER = 1'h0;
	localparam logic RESET_LONG_SEQ = 1'h0;
	localparam logic RESET_RUN = 1'h0;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// prbs generators
	localparam int PRBS_W = 15;
	localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7fff;
	localparam int PRBS9_TAP_A = 8;
	localparam int PRBS9_TAP_B = 4;
	localparam int PRBS15_TAP_A = 14;
	localparam int PRBS15_TAP_B = 13;
	localparam int PRBS9_LEN = 9;

	typedef enum logic [1:0] {
		PCPB_BUS_IDLE = 2'b00,
		PCPB_BUS_WRITE = 2'b01,
		PCPB_BUS_RDWAIT = 2'b10
	} pcpb_bus_t;
endpackage : pcpb_pkg

// File: verilog/pcpb_st_if.sv
// link between register block and self-test engine
`timescale 1ns/1ps
interface pcpb_st_if #(
	parameter int COUNT_W = 16
);
	logic run;
	logic long_seq;
	logic force_err;
	logic result;
	logic err_pulse;
	logic [COUNT_W-1:0] err_count;

	modport ctrl (
		output run,
		output long_seq,
		output force_err,
		input result,
		input err_pulse,
		input err_count
	);

	modport st (
		input run,
		input long_seq,
		input force_err,
		output result,
		output err_pulse,
		output err_count
	);
endinterface : pcpb_st_if

// File: verilog/pcpb_selftest.sv
// prbs self-test engine with error injection and error counting
`timescale 1ns/1ps
module pcpb_selftest #(
	parameter int COUNT_W = 16
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	pcpb_st_if.st st
);
	typedef struct packed {
		logic [pcpb_pkg::PRBS_W-1:0] gen;
		logic [pcpb_pkg::PRBS_W-1:0] chk;
		logic running;
		logic result;
		logic err_pulse;
		logic [COUNT_W-1:0] count;
	} pcpb_st_state_t;

	pcpb_st_state_t state;
	pcpb_st_state_t next_state;

	// one step of the selected lfsr
	function automatic logic [pcpb_pkg::PRBS_W-1:0] pcpb_prbs_step(
		input logic [pcpb_pkg::PRBS_W-1:0] cur,
		input logic long_seq
	);
		logic fb;
		logic [pcpb_pkg::PRBS_W-1:0] nxt;
		if (long_seq)
		begin
			fb = cur[pcpb_pkg::PRBS15_TAP_A] ^ cur[pcpb_pkg::PRBS15_TAP_B];
			nxt = {cur[pcpb_pkg::PRBS_W-2:0], fb};
		end
		else
		begin
			fb = cur[pcpb_pkg::PRBS9_TAP_A] ^ cur[pcpb_pkg::PRBS9_TAP_B];
			nxt = '0;
			nxt[pcpb_pkg::PRBS9_LEN-1:0] = {cur[pcpb_pkg::PRBS9_LEN-2:0], fb};
		end
		return nxt;
	endfunction : pcpb_prbs_step

	// serial bit leaving the lfsr
	function automatic logic pcpb_prbs_bit(
		input logic [pcpb_pkg::PRBS_W-1:0] cur,
		input logic long_seq
	);
		return long_seq ? cur[pcpb_pkg::PRBS_W-1] : cur[pcpb_pkg::PRBS9_LEN-1];
	endfunction : pcpb_prbs_bit

	logic tx_bit;
	logic ref_bit;

	always_comb
	begin
		next_state = state;
		next_state.err_pulse = 1'b0;
		tx_bit = pcpb_prbs_bit(state.gen, st.long_seq) ^ st.force_err;
		ref_bit = pcpb_prbs_bit(state.chk, st.long_seq);
		if (!st.run)
		begin
			next_state.running = 1'b0;
			next_state.result = 1'b0;
		end
		else if (!state.running)
		begin
			next_state.running = 1'b1;
			next_state.result = 1'b1;
			next_state.gen = pcpb_pkg::PRBS_SEED;
			next_state.chk = pcpb_pkg::PRBS_SEED;
			next_state.count = '0;
		end
		else
		begin
			next_state.gen = pcpb_prbs_step(state.gen, st.long_seq);
			next_state.chk = pcpb_prbs_step(state.chk, st.long_seq);
			if (tx_bit != ref_bit)
			begin
				next_state.err_pulse = 1'b1;
				next_state.result = 1'b0;
				if (state.count != '1)
				begin
					next_state.count = state.count + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign st.result = state.result;
	assign st.err_pulse = state.err_pulse;
	assign st.err_count = state.count;
endmodule : pcpb_selftest

// File: verif/pcpb_ctrl_sva.sv
// assertion checker for the phy control register block
`timescale 1ns/1ps
module pcpb_ctrl_sva (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic hsel_in,
	input wire logic [pcpb_pkg::ADDR_W-1:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire logic an_complete_in,
	input wire logic hcd_full_duplex_in,
	input wire logic [1:0] local_ability_advert_in,
	input wire logic [1:0] partner_ability_in,
	input wire logic auto_crossover_enable_out,
	input wire logic force_crossover_out,
	input wire logic pause_rx_out,
	input wire logic pause_tx_out,
	input wire logic selftest_run_out,
	input wire logic long_sequence_select_out
);
	logic take, wr_ctl, ok, rx_exp, tx_exp;
	logic [1:0] l, p;
	assign l = local_ability_advert_in;
	assign p = partner_ability_in;
	assign take = hsel_in && hready_in && htrans_in == pcpb_pkg::HTRANS_NONSEQ;
	assign wr_ctl = take && hwrite_in && haddr_in[7:2] == pcpb_pkg::REG_IDX_PHY_CONTROL[5:0];
	assign ok = an_complete_in && hcd_full_duplex_in;
	// pause resolution table
	assign rx_exp = ok && l[0] && (p[0] || (l[1] && p[1]));
	assign tx_exp = ok && p[0] && (l[0] || (l[1] && p[1]));
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	property p_okay;
		hresp_out == pcpb_pkg::HRESP_OKAY;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rd_wait;
		take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_ready;
		take && hwrite_in |=> hreadyout_out;
	endproperty
	a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
	property p_xover;
		wr_ctl ##1 1'b1 |=> auto_crossover_enable_out == $past(hwdata_in[15]);
	endproperty
	a_xover: assert property (p_xover) else $error("crossover enable wrong");
	property p_force_seq;
		wr_ctl ##1 1'b1 |=> force_crossover_out == $past(hwdata_in[14])
			&& long_sequence_select_out == $past(hwdata_in[10]);
	endproperty
	a_force_seq: assert property (p_force_seq) else $error("force or sequence wrong");
	property p_run;
		wr_ctl ##1 1'b1 |=> selftest_run_out == $past(hwdata_in[8]);
	endproperty
	a_run: assert property (p_run) else $error("run bit wrong");
	property p_gate;
		!ok |=> !pause_rx_out && !pause_tx_out;
	endproperty
	a_gate: assert property (p_gate) else $error("pause without full duplex");
	property p_rx;
		1'b1 |=> pause_rx_out == $past(rx_exp);
	endproperty
	a_rx: assert property (p_rx) else $error("pause rx wrong");
	property p_tx;
		1'b1 |=> pause_tx_out == $past(tx_exp);
	endproperty
	a_tx: assert property (p_tx) else $error("pause tx wrong");
endmodule : pcpb_ctrl_sva
bind pcpb_ctrl pcpb_ctrl_sva i_sva (.*);

// File: verif/pcpb_ctrl_bench.sv
// self-checking bench for the phy control register block
`timescale 1ns/1ps
module pcpb_ctrl_bench;
	localparam logic [7:0] A_PHY = pcpb_pkg::REG_IDX_PHY_CONTROL << 2;
	localparam logic [7:0] A_CNT = pcpb_pkg::REG_IDX_ERR_COUNT << 2;
	localparam logic [7:0] A_STS = pcpb_pkg::REG_IDX_INT_STATUS << 2;
	localparam logic [7:0] A_MSK = pcpb_pkg::REG_IDX_INT_MASK << 2;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic an = 1'b0;
	logic fd = 1'b0;
	logic [1:0] loc = 2'h0;
	logic [1:0] lp = 2'h0;
	logic [31:0] hrdata, rd, v;
	logic hrdy, hresp, axo, fxo, prx, ptx, run, lseq, irq;
	int bad_count = 0;
	int n_tests = 0;
	// an, fd, local, partner, rx, tx
	logic [7:0] rows [9] = '{8'hd7, 8'hfa, 8'hed, 8'hff, 8'hcc, 8'he8, 8'h94, 8'hd8, 8'h7c};
	always #12.5 clk = ~clk;
	pcpb_ctrl i_dut (
		.clk_sys_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
		.xover_strap_in(1'b1), .an_complete_in(an), .hcd_full_duplex_in(fd),
		.local_ability_advert_in(loc), .partner_ability_in(lp),
		.auto_crossover_enable_out(axo), .force_crossover_out(fxo), .pause_rx_out(prx),
		.pause_tx_out(ptx), .selftest_run_out(run), .long_sequence_select_out(lseq),
		.irq_out(irq)
	);
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// wait for hready sampled high at an edge
	task automatic hwait;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hrdy !== 1'b1 && n < 20);
		if (hrdy !== 1'b1)
		begin
			bad_count++;
			close_out();
		end
	endtask : hwait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= pcpb_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask : rchk
	initial
	begin
		repeat (20) @(posedge clk);
		chk("ready in reset", 32'h1, hrdy);
		chk("xover in reset", 32'h0, axo);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		chk("xover strap", 32'h1, axo);
		rchk("mask reset", A_MSK, 32'h0);
		foreach (rows[i])
		begin
			{an, fd, loc, lp} <= rows[i][7:2];
			repeat (3) @(posedge clk);
			chk("pause rx", {31'h0, rows[i][1]}, prx);
			chk("pause tx", {31'h0, rows[i][0]}, ptx);
			rchk("pause bits", A_PHY, {16'h0, 2'h2, rows[i][1:0], 12'h0});
		end
		wr(A_PHY, 32'h4400);
		@(posedge clk);
		chk("auto xover", 32'h0, axo);
		chk("force xover", 32'h1, fxo);
		chk("long seq", 32'h1, lseq);
		rchk("phy_control", A_PHY, 32'h4400);
		for (int s = 0; s < 2; s++)
		begin
			v = s ? 32'h0500 : 32'h0100;
			wr(A_PHY, v);
			repeat (8) @(posedge clk);
			chk("run", 32'h1, run);
			rchk("result pass", A_PHY, v | 32'h0200);
			rchk("count zero", A_CNT, 32'h0);
			wr(A_PHY, 32'h0);
			repeat (2) @(posedge clk);
			rchk("result stop", A_PHY, 32'h0);
			wr(A_PHY, v);
			wr(A_PHY, v | 32'h0800);
			repeat (8) @(posedge clk);
			rchk("result fail", A_PHY, v);
			rchk("error count", A_CNT, 32'h1);
			wr(A_PHY, 32'h0);
		end
		rchk("status", A_STS, 32'h3);
		chk("irq masked", 32'h0, irq);
		wr(A_MSK, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq error", 32'h1, irq);
		wr(A_STS, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, irq);
		rchk("status w1c", A_STS, 32'h2);
		wr(A_MSK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq pause", 32'h1, irq);
		wr(A_STS, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq off", 32'h0, irq);
		rchk("mask", A_MSK, 32'h2);
		wr(8'h00, 32'hffffffff);
		rchk("unmapped", 8'h00, 32'h0);
		close_out();
	end
endmodule : pcpb_ctrl_bench
